/* core/exdec_addr_gen.sv */
// Indexed address generator: frame pointer plus 7-bit offset, with indirect check
`timescale 1ns/100ps
module exdec_addr_gen
  import exdec_pkg::*;
(
  input  wire logic [11:0] base,
  input  wire logic [6:0]  offset,
  output logic      [11:0] addr,
  output logic             indirect
);
  // Sum wraps inside the 4096-byte data space
  always_comb begin
    addr     = 12'(base + {5'h00, offset});
    indirect = (addr >= EXDEC_INDF_LO) && (addr <= EXDEC_INDF_HI);
  end
endmodule

/* core/exdec_core.sv */
// Extension decode and execute block for the 8-bit core
`timescale 1ns/100ps
module exdec_core
  import exdec_pkg::*;
#(
  parameter int PTR_W = 12
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ext_set_enable_cfg,     // Nonvolatile configuration bit
  input  wire logic             instr_valid,            // Fetched word valid this cycle
  input  wire logic [15:0]      instr_word,             // Fetched instruction word
  input  wire logic [20:0]      instr_addr,             // Address of the fetched word
  input  wire logic [7:0]       working_register,
  input  wire logic [7:0]       prog_counter_high_latch,
  input  wire logic [7:0]       prog_counter_upper_latch,
  input  wire logic [20:0]      return_stack_top,
  input  wire logic [PTR_W-1:0] ptr_in [3],             // Current pointer values
  input  wire logic [7:0]       dmem_rdata,             // Read data at dmem_raddr
  input  wire logic             std_access_bit,         // Access-bank bit of standard op
  input  wire logic [7:0]       std_file_addr,          // File field of standard op
  input  wire logic [3:0]       std_bank_sel,           // Bank select for banked access
  output logic      [PTR_W-1:0] ptr_out [3],            // Updated pointer values
  output logic      [2:0]       ptr_we,                 // Pointer write strobes
  output exdec_dwr_t            dmem_wr,                // Data memory write
  output logic      [11:0]      dmem_raddr,             // Data memory read address
  output exdec_pc_t             pc_ctl,                 // Program counter control
  output logic      [11:0]      std_eff_addr,           // Standard op effective address
  output logic                  ext_claim,              // Word taken as extension op
  output logic                  busy                    // Second cycle in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  exdec_state_t     state, next_state;
  logic             ext_on, next_ext_on;                // Latched enable
  logic [PTR_W-1:0] next_ptr [3];
  logic [2:0]       next_ptr_we;
  exdec_dwr_t       next_dmem_wr;
  logic [11:0]      next_dmem_raddr;
  exdec_pc_t        next_pc_ctl;
  logic [11:0]      next_std_eff_addr;
  logic             next_claim, next_busy;
  logic [7:0]       move_data, next_move_data;          // Byte read in second move cycle
  logic             move_ss, next_move_ss;              // Destination is indexed
  logic [11:0]      src_addr, dst_addr;
  logic             src_ind, dst_ind;
  logic             src_ind_q;                          // Source of the pending move is indirect
  logic [1:0]       sel;
  logic [5:0]       lit6;

  assign sel  = instr_word[7:6];
  assign lit6 = instr_word[5:0];

  // Source and destination use separate generators with the same inputs
  exdec_addr_gen u_src (
    .base     (ptr_in[EXDEC_FRAME_IDX]),
    .offset   (instr_word[6:0]),
    .addr     (src_addr),
    .indirect (src_ind)
  );
  exdec_addr_gen u_dst (
    .base     (ptr_in[EXDEC_FRAME_IDX]),
    .offset   (instr_word[6:0]),
    .addr     (dst_addr),
    .indirect (dst_ind)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state        = state;
    // Enable only follows the configuration bit, never a software write
    next_ext_on       = ext_set_enable_cfg;
    next_ptr          = ptr_out;
    next_ptr_we       = '0;
    next_dmem_wr      = '0;
    next_dmem_raddr   = dmem_raddr;
    next_pc_ctl       = '0;
    next_claim        = 1'b0;
    next_busy         = 1'b0;
    next_move_data    = move_data;
    next_move_ss      = move_ss;
    // Standard addressing: access bank splits low RAM and high SFRs
    if (!std_access_bit) begin
      next_std_eff_addr = (std_file_addr > EXDEC_IDX_LIMIT) ?
                          {4'hF, std_file_addr} : {4'h0, std_file_addr};
      if (ext_on && std_file_addr <= EXDEC_IDX_LIMIT) begin
        // Frame-relative window replaces the low access bank
        next_std_eff_addr = 12'(ptr_in[EXDEC_FRAME_IDX] + {4'h0, std_file_addr});
      end
    end else begin
      next_std_eff_addr = {std_bank_sel, std_file_addr};
    end
    case (state)
      EXDEC_IDLE: begin
        // Nothing decodes here while disabled; the standard decoder owns it
        if (instr_valid && ext_on) begin
          if (instr_word[15:8] == EXDEC_OP_ADD_PTR) begin
            next_claim = 1'b1;
            if (sel == EXDEC_SEL_FRAME) begin
              next_ptr[EXDEC_FRAME_IDX] = ptr_in[EXDEC_FRAME_IDX] + PTR_W'(lit6);
              next_ptr_we[EXDEC_FRAME_IDX] = 1'b1;
              next_state = EXDEC_RET;
            end else begin
              // Zero-extended literal, status untouched
              next_ptr[sel]    = ptr_in[sel] + PTR_W'(lit6);
              next_ptr_we[sel] = 1'b1;
            end
          end else if (instr_word[15:8] == EXDEC_OP_SUB_PTR) begin
            next_claim = 1'b1;
            if (sel == EXDEC_SEL_FRAME) begin
              next_ptr[EXDEC_FRAME_IDX] = ptr_in[EXDEC_FRAME_IDX] - PTR_W'(lit6);
              next_ptr_we[EXDEC_FRAME_IDX] = 1'b1;
              next_state = EXDEC_RET;
            end else begin
              next_ptr[sel]    = ptr_in[sel] - PTR_W'(lit6);
              next_ptr_we[sel] = 1'b1;
            end
          end else if (instr_word[15:8] == EXDEC_OP_PUSH_LIT) begin
            next_claim = 1'b1;
            // Write at the old pointer, then step it down
            next_dmem_wr.we   = 1'b1;
            next_dmem_wr.addr = 12'(ptr_in[EXDEC_FRAME_IDX]);
            next_dmem_wr.data = instr_word[7:0];
            next_ptr[EXDEC_FRAME_IDX]    = ptr_in[EXDEC_FRAME_IDX] - PTR_W'(EXDEC_PUSH_STEP);
            next_ptr_we[EXDEC_FRAME_IDX] = 1'b1;
          end else if (instr_word == EXDEC_OP_CALL_WORKING_REGISTER) begin
            next_claim = 1'b1;
            next_pc_ctl.push     = 1'b1;
            next_pc_ctl.ret_addr = instr_addr + EXDEC_RET_STEP;
            next_pc_ctl.load     = 1'b1;
            next_pc_ctl.target   = {prog_counter_upper_latch[4:0],
                                    prog_counter_high_latch, working_register};
            next_state = EXDEC_CALL;
          end else if (instr_word[15:8] == EXDEC_OP_MOVE_IDX) begin
            next_claim      = 1'b1;
            next_move_ss    = instr_word[7];
            next_dmem_raddr = src_addr;
            next_state      = EXDEC_MOVE2;
          end
        end
      end
      EXDEC_RET: begin
        // Second cycle loads the program counter from the return stack top
        next_busy          = 1'b1;
        next_pc_ctl.load   = 1'b1;
        next_pc_ctl.target = return_stack_top;
        next_state         = EXDEC_IDLE;
      end
      EXDEC_CALL: begin
        next_busy  = 1'b1;
        next_state = EXDEC_IDLE;
      end
      EXDEC_MOVE2: begin
        next_busy = 1'b1;
        // Indirect source would trigger a side effect; hand back zero instead
        next_move_data = src_ind_q ? EXDEC_ZERO_BYTE : dmem_rdata;
        if (instr_valid && instr_word[15:12] == EXDEC_OP_SECOND_HI) begin
          next_dmem_wr.data = src_ind_q ? EXDEC_ZERO_BYTE : dmem_rdata;
          if (move_ss) begin
            next_dmem_wr.addr = dst_addr;
            next_dmem_wr.we   = !dst_ind;
          end else begin
            next_dmem_wr.addr = instr_word[11:0];
            next_dmem_wr.we   = 1'b1;
          end
          next_state = EXDEC_IDLE;
        end
      end
      default: next_state = EXDEC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset forces the extension off

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state        <= EXDEC_IDLE;
      ext_on       <= 1'b0;
      ptr_out      <= '{default: '0};
      ptr_we       <= '0;
      dmem_wr      <= '0;
      dmem_raddr   <= '0;
      pc_ctl       <= '0;
      std_eff_addr <= '0;
      ext_claim    <= 1'b0;
      busy         <= 1'b0;
      move_data    <= '0;
      move_ss      <= 1'b0;
      src_ind_q    <= 1'b0;
    end else begin
      state        <= next_state;
      ext_on       <= next_ext_on;
      ptr_out      <= next_ptr;
      ptr_we       <= next_ptr_we;
      dmem_wr      <= next_dmem_wr;
      dmem_raddr   <= next_dmem_raddr;
      pc_ctl       <= next_pc_ctl;
      std_eff_addr <= next_std_eff_addr;
      ext_claim    <= next_claim;
      busy         <= next_busy;
      move_data    <= next_move_data;
      move_ss      <= next_move_ss;
      // Remember whether the source just addressed is indirect
      src_ind_q    <= (state == EXDEC_IDLE) ? src_ind : src_ind_q;
    end
  end

endmodule

/* inc/exdec_pkg.sv */
// Package: constants, opcodes, states and carrier structs for the extension decoder
package exdec_pkg;

  // Opcode field values (first-word upper byte; second-word upper nibble; whole call word)
  localparam logic [7:0]  EXDEC_OP_ADD_PTR   = 8'h00_E8;
  localparam logic [7:0]  EXDEC_OP_SUB_PTR   = 8'h00_E9;
  localparam logic [7:0]  EXDEC_OP_PUSH_LIT  = 8'h00_EA;
  localparam logic [7:0]  EXDEC_OP_MOVE_IDX  = 8'h00_EB;
  localparam logic [3:0]  EXDEC_OP_SECOND_HI = 4'h0_F;
  localparam logic [15:0] EXDEC_OP_CALL_WORKING_REGISTER = 16'h0014;
  localparam logic [1:0]  EXDEC_SEL_FRAME    = 2'h3;
  localparam logic [1:0]  EXDEC_FRAME_IDX    = 2'h2;
  // Indexed literal offset window ends at this file address
  localparam logic [7:0]  EXDEC_IDX_LIMIT    = 8'h5F;
  // Return address is the call's address plus two bytes
  localparam logic [20:0] EXDEC_RET_STEP     = 21'h00_0002;
  localparam logic [11:0] EXDEC_PUSH_STEP    = 12'h001;
  localparam logic [7:0]  EXDEC_ZERO_BYTE    = 8'h00;
  // Indirect addressing registers live in this data address range
  localparam logic [11:0] EXDEC_INDF_LO      = 12'hFDF;
  localparam logic [11:0] EXDEC_INDF_HI      = 12'hFEF;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    EXDEC_IDLE   = 4'b0001,
    EXDEC_RET    = 4'b0010,
    EXDEC_CALL   = 4'b0100,
    EXDEC_MOVE2  = 4'b1000
  } exdec_state_t;

  // Data memory write request
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } exdec_dwr_t;

  // Program counter load request
  typedef struct packed {
    logic        push;
    logic [20:0] ret_addr;
    logic        load;
    logic [20:0] target;
  } exdec_pc_t;

endpackage

/* verif/exdec_core_asserts.sv */
// Checker: timing and value relations at the extension decoder ports
`timescale 1ns/100ps
module exdec_core_asserts
  import exdec_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ext_set_enable_cfg,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [20:0] instr_addr,
  input wire logic [7:0]  working_register,
  input wire logic [7:0]  prog_counter_high_latch,
  input wire logic [20:0] return_stack_top,
  input wire logic        std_access_bit,
  input wire logic [7:0]  std_file_addr,
  input wire logic [3:0]  std_bank_sel,
  input wire logic [2:0]  ptr_we,
  input wire exdec_dwr_t  dmem_wr,
  input wire exdec_pc_t   pc_ctl,
  input wire logic [11:0] std_eff_addr,
  input wire logic        ext_claim,
  input wire logic        busy
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Two low samples of the enable bit cover either reading of its latency
  a_off_idle: assert property (
    !$past(ext_set_enable_cfg) && !$past(ext_set_enable_cfg, 2)
    |-> !ext_claim && ptr_we == 3'h0 && !dmem_wr.we && !pc_ctl.load)
    else $error("extension acted while disabled");
  a_claim_cause: assert property (ext_claim |-> $past(instr_valid))
    else $error("claim without a fetched word");
  a_add_sel: assert property (
    ext_claim && $past(instr_word[15:9] == 7'h74 && instr_word[7:6] != EXDEC_SEL_FRAME)
    |-> ptr_we == (3'h1 << $past(instr_word[7:6])) && !pc_ctl.load)
    else $error("wrong pointer strobe for add or subtract");
  a_ret_frame: assert property (
    ext_claim && $past(instr_word[15:9] == 7'h74 && instr_word[7:6] == EXDEC_SEL_FRAME)
    |-> ptr_we == 3'h4 && !pc_ctl.load
    ##1 pc_ctl.load && busy && !ext_claim && pc_ctl.target == return_stack_top)
    else $error("return form sequence wrong");
  a_push_frame: assert property (
    ext_claim && $past(instr_word[15:8] == EXDEC_OP_PUSH_LIT)
    |-> dmem_wr.we && dmem_wr.data == $past(instr_word[7:0]) && ptr_we == 3'h4)
    else $error("literal push wrong");
  a_call_working_register: assert property (
    ext_claim && $past(instr_word == EXDEC_OP_CALL_WORKING_REGISTER)
    |-> pc_ctl.push && pc_ctl.load && pc_ctl.ret_addr == $past(instr_addr) + EXDEC_RET_STEP
    && pc_ctl.target[15:0] == {$past(prog_counter_high_latch), $past(working_register)}
    ##1 busy && !ext_claim)
    else $error("call through working register wrong");
  a_move_write: assert property (
    ext_claim && $past(instr_word[15:7] == 9'h1D6) && instr_valid
    && instr_word[15:12] == EXDEC_OP_SECOND_HI
    |=> dmem_wr.we && busy && dmem_wr.addr == $past(instr_word[11:0]))
    else $error("indexed move write wrong");
  a_std_addr: assert property (
    // The first edge after reset still shows the reset value, so skip it
    $past(rst_n) && !$past(ext_set_enable_cfg) && !$past(ext_set_enable_cfg, 2)
    |-> std_eff_addr == {($past(std_access_bit) ? $past(std_bank_sel)
    : ($past(std_file_addr) > EXDEC_IDX_LIMIT ? 4'hF : 4'h0)), $past(std_file_addr)})
    else $error("standard address wrong while disabled");
  c_ret: cover property (pc_ctl.load && busy);
  c_move: cover property (dmem_wr.we && busy);
  c_call: cover property (pc_ctl.push);
endmodule

/* verif/exdec_mem_model.sv */
// Partner model: pointer registers and data memory behind the decoder
`timescale 1ns/100ps
module exdec_mem_model
  import exdec_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [11:0] ptr_out [3],
  input  wire logic [2:0]  ptr_we,
  input  wire exdec_dwr_t  dmem_wr,
  input  wire logic [11:0] dmem_raddr,
  output logic      [11:0] ptr_in [3],
  output logic      [7:0]  dmem_rdata
);
  logic [7:0]  mem [4096];  // Preset to low address byte XOR 5A, so a forced zero read shows
  logic [11:0] ptr_q [3];   // Stored pointer registers
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
    ptr_q = '{12'h010, 12'h020, 12'hF80};
  end
  // Read follows the held address, so data stands in the cycle after it moves
  assign dmem_rdata = mem[dmem_raddr];
  // A pending pointer write is forwarded, so back-to-back ops see the new value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ptr_in[i] = ptr_we[i] ? ptr_out[i] : ptr_q[i];
    end
  end
  always @(posedge ref_clk) begin
    if (dmem_wr.we) begin
      mem[dmem_wr.addr] <= dmem_wr.data;
    end
    for (int i = 0; i < 3; i++) begin
      if (ptr_we[i]) begin
        ptr_q[i] <= ptr_out[i];
      end
    end
  end
endmodule

/* verif/tb_top.sv */
// Testbench: directed scenarios for the extension decoder
`timescale 1ns/100ps
module tb_top
  import exdec_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ext_set_enable_cfg = 1'b0;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic        std_access_bit = 1'b0;
  logic [7:0]  std_file_addr = 8'h00;
  logic [3:0]  std_bank_sel = 4'h0;
  logic [11:0] ptr_in [3];
  logic [11:0] ptr_out [3];
  logic [2:0]  ptr_we;
  exdec_dwr_t  dmem_wr;
  logic [11:0] dmem_raddr, std_eff_addr, e;
  logic [7:0]  dmem_rdata;
  exdec_pc_t   pc_ctl;
  exdec_pc_t   pc_seen = '0; // Last program counter load
  logic        ext_claim, busy;
  int          miscompares = 0;
  int          comparisons = 0;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (pc_ctl.load) pc_seen <= pc_ctl;
  exdec_core dut (.ref_clk, .rst_n, .ext_set_enable_cfg, .instr_valid, .instr_word,
    .instr_addr(21'h00_0100), .working_register(8'h06), .prog_counter_high_latch(8'h10),
    .prog_counter_upper_latch(8'h00), .return_stack_top(21'h0_ABCD), .ptr_in, .dmem_rdata,
    .std_access_bit, .std_file_addr, .std_bank_sel, .ptr_out, .ptr_we, .dmem_wr,
    .dmem_raddr, .pc_ctl, .std_eff_addr, .ext_claim, .busy);
  exdec_mem_model u_mem (.ref_clk, .ptr_out, .ptr_we, .dmem_wr, .dmem_raddr, .ptr_in,
    .dmem_rdata);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [20:0] x, input logic [20:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  // One word per call; calls in a row give back-to-back words
  task automatic put(input logic [15:0] w);
    @(posedge ref_clk) #1 instr_valid = 1'b1;
    instr_word = w;
  endtask
  // Idle slot, then wait until pointer and memory writes have landed
  task automatic stop();
    @(posedge ref_clk) #1 instr_valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_disabled();
    put(16'hE845);
    stop();
    chk("ptr1_off", 21'h20, 21'(ptr_in[1]));
    chk("eff_off", 21'h10, 21'(std_eff_addr));
  endtask
  task automatic t_move();
    put(16'hEB05);
    put(16'hF123);
    stop();
    chk("move_file", 21'hDF, 21'(u_mem.mem[12'h123]));
    put(16'hEB60);
    put(16'hF124);
    stop();
    chk("move_indir_src", 21'h0, 21'(u_mem.mem[12'h124]));
    put(16'hEB85);
    put(16'hF060);
    stop();
    chk("move_indir_dst", 21'hBA, 21'(u_mem.mem[12'hFE0]));
    put(16'hEB85);
    put(16'hF006);
    stop();
    chk("move_idx_dst", 21'hDF, 21'(u_mem.mem[12'hF86]));
  endtask
  task automatic t_push();
    put(16'hEA08);
    stop();
    chk("push_mem", 21'h08, 21'(u_mem.mem[12'hF80]));
    chk("push_ptr", 21'hF7F, 21'(ptr_in[2]));
  endtask
  task automatic t_ret();
    put(16'hE8C5);
    put(16'hE841); // Lands in the second cycle and must be ignored
    stop();
    chk("addret_ptr", 21'hF84, 21'(ptr_in[2]));
    chk("addret_pc", 21'h0_ABCD, pc_seen.target);
    chk("busy_refuse", 21'h20, 21'(ptr_in[1]));
    pc_seen = '0;
    put(16'hE9C3);
    stop();
    chk("subret_ptr", 21'hF81, 21'(ptr_in[2]));
    chk("subret_pc", 21'h0_ABCD, pc_seen.target);
  endtask
  task automatic t_add_sub();
    for (int f = 0; f < 3; f++) begin
      e = ptr_in[f] + 12'h03E;
      put({8'hE8, f[1:0], 6'h3F});
      put({8'hE9, f[1:0], 6'h01});
      stop();
      chk("ptr_addsub", 21'(e), 21'(ptr_in[f]));
    end
  endtask
  task automatic t_call();
    put(16'h0014);
    stop();
    chk("call_target", 21'h00_1006, pc_seen.target);
    chk("call_ret", 21'h102, pc_seen.ret_addr);
  endtask
  task automatic t_idx();
    std_file_addr = 8'h10;
    stop();
    chk("eff_idx", 21'(ptr_in[2] + 12'h010), 21'(std_eff_addr));
    std_file_addr = 8'h60;
    stop();
    chk("eff_acc_hi", 21'hF60, 21'(std_eff_addr));
    std_access_bit = 1'b1;
    std_bank_sel = 4'h7;
    stop();
    chk("eff_bank", 21'h760, 21'(std_eff_addr));
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence: disabled first, then every extended operation
  initial begin
    std_file_addr = 8'h10;
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_disabled();
    ext_set_enable_cfg = 1'b1;
    stop();
    t_move();
    t_push();
    t_ret();
    t_add_sub();
    t_call();
    t_idx();
    report_and_stop();
  end
  // Watchdog: the sequence needs well under a thousand clocks
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
bind exdec_core exdec_core_asserts u_chk (.ref_clk, .rst_n, .ext_set_enable_cfg, .instr_valid,
  .instr_word, .instr_addr, .working_register, .prog_counter_high_latch, .return_stack_top,
  .std_access_bit, .std_file_addr, .std_bank_sel, .ptr_we, .dmem_wr, .pc_ctl, .std_eff_addr,
  .ext_claim, .busy);
